//--- logic/tss_top.v
// Slave status and interrupt sequencing of a two-wire bus controller.
// Assumes an outside master drives scl/sda; registers on a plain port.
// Operation
// - Slave start: status 00000010, interrupt only with start enable.
// - Stop: status 00000001, interrupt only with stop enable.
// - Own address match always interrupts after address, pattern 0001x110.
// - Eighth-clock timing: each received byte interrupts as 0001x000.
// - Ninth-clock timing: bytes report 0001x100, last byte 0001xx00.
// - Restart with own address reports 0001x110 again, data as before.
// - Extension code interrupts with 0010x010; eighth-clock bytes 0010x000.
// - Ninth-clock extension adds 0010x110 after code; bytes 0010xx00.
// - Unmatched restart address interrupts once 0000xx10, then only stop.
// - Unaddressed transfer gives only gated start and stop reports.
// - Start issued as master reads 10001010.
// - Lost address arbitration with own match: 0101x110, then slave data.
// - Lost extension-code arbitration: 0110x010, then extension patterns.
// - Lost arbitration, not addressed: 0100x110 once, then only stop.
// - Software release bit makes device leave transfer; only stop follows.
// - Arbitration-lost flag stays readable until the following event.
// - Ninth-clock select picks eighth or ninth clock data interrupts.
// - Status bit 0 is stop-detected; stop irq needs it and enable.
// - Status bit 3 takes the direction bit after the address.
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "tss_defs.vh"
module tss_top (
    input wire clk_in,
    input wire rst_n_in,
    input wire ce_in,
    input wire scl_in,
    input wire sda_in,
    input wire [1:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire mstr_start_in,
    input wire arb_lost_in,
    output reg [7:0] rdata_out,
    output reg irq_out,
    output wire sda_oe_n_out,
    output wire sda_drv_out
);
    localparam ST_IDLE = 5'h01;
    localparam ST_ADDR = 5'h02;
    localparam ST_DATA = 5'h04;
    localparam ST_EXT = 5'h08;
    localparam ST_SKIP = 5'h10;

    reg rst_a_q;
    reg rst_b_q;
    wire rst_n;
    wire scl_s;
    wire sda_s;
    reg scl_q;
    reg sda_q;
    reg [7:0] ctrl_q;
    reg [7:0] own_q;
    reg [7:0] stat_q;
    reg [4:0] state_q;
    reg [3:0] bit_cnt_q;
    reg mstr_q;
    reg ald_q;
    reg ald_hold_q;
    reg ack_q;
    reg ack_drive_q;
    reg first_ext_q;
    reg pend_q;
    reg [7:0] pend_val_q;
    wire [7:0] shreg;
    wire scl_rise;
    wire scl_fall;
    wire start_ev;
    wire stop_ev;
    wire ninth;
    wire own_hit;
    wire ext_hit;

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_a_q <= 1'b0;
            rst_b_q <= 1'b0;
        end else begin
            rst_a_q <= 1'b1;
            rst_b_q <= rst_a_q;
        end
    end
    assign rst_n = rst_b_q;

    tss_sync u_scl (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .ce_in(ce_in),
        .d_in(scl_in),
        .q_out(scl_s)
    );
    tss_sync u_sda (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .ce_in(ce_in),
        .d_in(sda_in),
        .q_out(sda_s)
    );

    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else if (ce_in) begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    assign start_ev = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_ev = scl_s & scl_q & ~sda_q & sda_s;
    assign ninth = ctrl_q[`TSS_C_NINTH];
    assign own_hit = (shreg[7:1] == own_q[7:1]);
    assign ext_hit = (shreg[7:4] == `TSS_EXT_PREFIX);

    tss_shift u_shift (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .ce_in(ce_in),
        .clear_in(start_ev),
        .sample_in(scl_rise & (bit_cnt_q < `TSS_BIT9)),
        .bit_in(sda_s),
        .data_out(shreg)
    );

    // Ack is driven low on the ninth clock once addressed
    assign sda_drv_out = 1'b0;
    assign sda_oe_n_out = ~ack_drive_q;

    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `TSS_CTRL_RST;
            own_q <= `TSS_OWN_RST;
            rdata_out <= 8'h00;
        end else if (ce_in) begin
            if (wr_in && addr_in == `TSS_ADDR_CTRL) begin
                ctrl_q <= wdata_in;
            end else if (wr_in && addr_in == `TSS_ADDR_OWN) begin
                own_q <= wdata_in;
            end else if (state_q == ST_IDLE) begin
                ctrl_q[`TSS_C_RELEASE] <= 1'b0;
            end
            if (rd_in) begin
                case (addr_in)
                    `TSS_ADDR_CTRL: rdata_out <= ctrl_q;
                    `TSS_ADDR_STAT: rdata_out <= stat_q;
                    `TSS_ADDR_OWN: rdata_out <= own_q;
                    default: rdata_out <= {7'h00, mstr_q};
                endcase
            end
        end
    end

    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            stat_q <= 8'h00;
            irq_out <= 1'b0;
            mstr_q <= 1'b0;
            ald_q <= 1'b0;
            ald_hold_q <= 1'b0;
            ack_q <= 1'b0;
            ack_drive_q <= 1'b0;
            first_ext_q <= 1'b0;
            pend_q <= 1'b0;
            pend_val_q <= 8'h00;
        end else if (ce_in) begin
            irq_out <= 1'b0;
            if (mstr_start_in) begin
                mstr_q <= 1'b1;
            end
            if (arb_lost_in && mstr_q) begin
                ald_q <= 1'b1;
                mstr_q <= 1'b0;
            end
            if (scl_rise && bit_cnt_q == `TSS_BIT9) begin
                ack_q <= ~sda_s;
            end
            if (stop_ev) begin
                // Stop always updates status; irq gated by enable
                stat_q <= `TSS_ST_STOP;
                irq_out <= ctrl_q[`TSS_C_STOP_IE];
                state_q <= ST_IDLE;
                mstr_q <= 1'b0;
                ald_q <= 1'b0;
                ald_hold_q <= 1'b0;
                ack_drive_q <= 1'b0;
                pend_q <= 1'b0;
            end else if (start_ev) begin
                bit_cnt_q <= 4'h0;
                ack_drive_q <= 1'b0;
                pend_q <= 1'b0;
                if (state_q == ST_IDLE) begin
                    // Master-issued start sets top bit
                    stat_q <= {mstr_q | mstr_start_in, 7'h00} |
                        `TSS_ST_START | {4'h0, mstr_q | mstr_start_in,
                        3'h0};
                    irq_out <= ctrl_q[`TSS_C_START_IE];
                end else if (pend_q) begin
                    // Restart: pend_q is never set to 1, so this branch makes no report
                    stat_q <= pend_val_q;
                    irq_out <= 1'b1;
                end
                state_q <= ST_ADDR;
            end else if (ctrl_q[`TSS_C_RELEASE] && state_q != ST_IDLE &&
                    state_q != ST_SKIP) begin
                state_q <= ST_SKIP;
                ack_drive_q <= 1'b0;
            end else if (scl_fall) begin
                bit_cnt_q <= (bit_cnt_q == `TSS_BIT9) ? 4'h1 :
                    bit_cnt_q + 4'h1;
                if (ald_hold_q) begin
                    // Flag cleared on the next clock fall after its report
                    ald_q <= 1'b0;
                end
                ack_drive_q <= 1'b0;
                case (state_q)
                    ST_ADDR: begin
                        // Ack driven from the eighth fall through the ninth
                        if (bit_cnt_q == `TSS_BIT8) begin
                            if (own_hit || ext_hit) begin
                                ack_drive_q <= 1'b1;
                            end
                        end
                        if (bit_cnt_q == `TSS_BIT8 && ext_hit) begin
                            // Extension code reported on eighth fall
                            stat_q <= {1'b0, ald_q, 2'h2, shreg[0],
                                3'h2};
                            irq_out <= 1'b1;
                            ald_hold_q <= ald_q;
                            first_ext_q <= ninth;
                            state_q <= ST_EXT;
                        end else if (bit_cnt_q == `TSS_BIT9) begin
                            if (own_hit) begin
                                stat_q <= {1'b0, ald_q, 2'h1, shreg[0],
                                    3'h6};
                                irq_out <= 1'b1;
                                ald_hold_q <= ald_q;
                                state_q <= ST_DATA;
                            end else if (ald_q || stat_q[`TSS_S_COI] ||
                                    stat_q[`TSS_S_EXC]) begin
                                // Reported once, then silent
                                stat_q <= {1'b0, ald_q, 2'h0, shreg[0],
                                    ald_q | ack_q, 2'h2};
                                irq_out <= 1'b1;
                                ald_hold_q <= ald_q;
                                state_q <= ST_SKIP;
                            end else begin
                                state_q <= ST_SKIP;
                            end
                        end
                        if (bit_cnt_q == `TSS_BIT8) begin
                            stat_q[`TSS_S_TRC] <= shreg[0];
                        end
                    end
                    ST_EXT, ST_DATA: begin
                        if (first_ext_q && bit_cnt_q == `TSS_BIT9) begin
                            stat_q <= {4'h2, stat_q[`TSS_S_TRC], 3'h6};
                            irq_out <= 1'b1;
                            first_ext_q <= 1'b0;
                        end else if (!ninth && bit_cnt_q == `TSS_BIT8) begin
                            stat_q <= {2'h0, state_q == ST_EXT,
                                state_q == ST_DATA, stat_q[`TSS_S_TRC],
                                3'h0};
                            irq_out <= 1'b1;
                            ack_drive_q <= 1'b1;
                        end else if (ninth && bit_cnt_q == `TSS_BIT9) begin
                            stat_q <= {2'h0, state_q == ST_EXT,
                                state_q == ST_DATA, stat_q[`TSS_S_TRC],
                                ack_q, 2'h0};
                            irq_out <= 1'b1;
                        end
                        if (ninth && bit_cnt_q == `TSS_BIT8) begin
                            ack_drive_q <= 1'b1;
                        end
                        pend_val_q <= {2'h0, state_q == ST_EXT,
                            state_q == ST_DATA, stat_q[`TSS_S_TRC],
                            ack_q, 2'h0};
                        pend_q <= 1'b0;
                    end
                    ST_SKIP, ST_IDLE: begin
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end
endmodule // tss_top
`default_nettype wire

//--- logic/tss_defs.vh
// Constants for the two-wire slave status sequencer.
// Assumes inclusion by bare name from the design files.
`ifndef TSS_DEFS_VH
`define TSS_DEFS_VH
`define TSS_ADDR_CTRL 2'h0
`define TSS_ADDR_STAT 2'h1
`define TSS_ADDR_OWN 2'h2
`define TSS_ADDR_MSTR 2'h3
`define TSS_CTRL_RST 8'h00
`define TSS_OWN_RST 8'h00
`define TSS_C_STOP_IE 4
`define TSS_C_NINTH 3
`define TSS_C_START_IE 1
`define TSS_C_RELEASE 6
`define TSS_S_MSTR 7
`define TSS_S_ALD 6
`define TSS_S_EXC 5
`define TSS_S_COI 4
`define TSS_S_TRC 3
`define TSS_S_ACKD 2
`define TSS_S_STD 1
`define TSS_S_SPD 0
`define TSS_ST_START 8'h02
`define TSS_ST_STOP 8'h01
`define TSS_EXT_PREFIX 4'hf
`define TSS_BIT8 4'h8
`define TSS_BIT9 4'h9
`endif

//--- logic/tss_sync.v
// Two-flop synchroniser for one asynchronous level.
// Assumes clk_in is the block clock; the first flop is read only by the second.
`timescale 1ns/1ns
`default_nettype none
module tss_sync (
    input wire clk_in,
    input wire rst_n_in,
    input wire ce_in,
    input wire d_in,
    output wire q_out
);
    reg meta_q;
    reg sync_q;
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end else if (ce_in) begin
            meta_q <= d_in;
            sync_q <= meta_q;
        end
    end
    assign q_out = sync_q;
endmodule // tss_sync
`default_nettype wire

//--- logic/tss_shift.v
// Serial shift register catching bits on rising bus clock edges.
// Assumes sample_in is a one-cycle pulse from synchronised lines.
`timescale 1ns/1ns
`default_nettype none
module tss_shift (
    input wire clk_in,
    input wire rst_n_in,
    input wire ce_in,
    input wire clear_in,
    input wire sample_in,
    input wire bit_in,
    output reg [7:0] data_out
);
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            data_out <= 8'h00;
        end else if (ce_in) begin
            if (clear_in) begin
                data_out <= 8'h00;
            end else if (sample_in) begin
                data_out <= {data_out[6:0], bit_in};
            end
        end
    end
endmodule // tss_shift
`default_nettype wire

//--- dv/tss_props.sv
// Port-level assertions for the slave status sequencer.
// Assumes a slow outside master on scl/sda; bound into tss_top.
`timescale 1ns/1ns
`default_nettype none
`include "tss_defs.vh"
module tss_props (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic [1:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic irq_out,
    input wire logic sda_oe_n_out,
    input wire logic sda_drv_out
);
    logic pie_q;
    logic [3:0] low_q;
    // Shadow of the stop report enable
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            pie_q <= 1'b0;
        else if (wr_in && addr_in == `TSS_ADDR_CTRL)
            pie_q <= wdata_in[`TSS_C_STOP_IE];
    end
    // Cycles since the serial clock fell
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            low_q <= 4'h0;
        else if (scl_in)
            low_q <= 4'h0;
        else if (low_q != 4'hf)
            low_q <= low_q + 4'h1;
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    sequence s_start_irq;
        irq_out && scl_in && !sda_in;
    endsequence
    sequence s_stop_irq;
        irq_out && scl_in && sda_in;
    endsequence
    property p_irq_pulse;
        irq_out |=> !irq_out;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("irq held over one cycle");
    property p_rd_hold;
        !rd_in |=> $stable(rdata_out);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data moved without a read");
    property p_stop_gate;
        s_stop_irq |-> pie_q;
    endproperty
    a_stop_gate: assert property (p_stop_gate)
        else $error("stop irq while stop enable clear");
    property p_stop_after;
        s_stop_irq |-> !$past(sda_in, 7);
    endproperty
    a_stop_after: assert property (p_stop_after)
        else $error("stop irq without a recent stop");
    property p_start_after;
        s_start_irq |-> $past(sda_in, 7);
    endproperty
    a_start_after: assert property (p_start_after)
        else $error("start irq without a recent start");
    property p_fall_delay;
        irq_out && !scl_in |-> low_q >= 4'h2 && low_q <= 4'h6;
    endproperty
    a_fall_delay: assert property (p_fall_delay)
        else $error("irq not tied to a clock fall");
    property p_oe_steady;
        scl_in && $past(scl_in) |-> $stable(sda_oe_n_out);
    endproperty
    a_oe_steady: assert property (p_oe_steady)
        else $error("data drive moved with clock high");
    property p_drv_low;
        sda_drv_out == 1'b0;
    endproperty
    a_drv_low: assert property (p_drv_low)
        else $error("data line driven high");
endmodule // tss_props
bind tss_top tss_props u_props (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl_in),
    .sda_in(sda_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .irq_out(irq_out), .sda_oe_n_out(sda_oe_n_out),
    .sda_drv_out(sda_drv_out)
);
`default_nettype wire

//--- dv/tss_bus_master.sv
// Outside bus master model driving serial clock and data.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ns
`default_nettype none
module tss_bus_master (
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_out
);
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // Start from idle, or restart with clock low
    task automatic start_cond();
        sda_out = 1'b1;
        #31;
        scl_out = 1'b1;
        #63;
        sda_out = 1'b0;
        #63;
        scl_out = 1'b0;
    endtask
    // Eight bits then a released acknowledge bit
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= -1; i--) begin
            #31;
            sda_out = (i < 0) ? 1'b1 : b[i];
            #31;
            scl_out = 1'b1;
            #31;
            ack = ~sda_in;
            #32;
            scl_out = 1'b0;
        end
    endtask
    task automatic stop_cond();
        #31;
        sda_out = 1'b0;
        #31;
        scl_out = 1'b1;
        #63;
        sda_out = 1'b1;
        #125;
    endtask
endmodule // tss_bus_master
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the slave status sequencer.
// Assumes tss_bus_master as the outside master; status read on each irq.
`timescale 1ns/1ns
`default_nettype none
`include "tss_defs.vh"
module testbench;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic ce_in = 1'b1;
    logic [1:0] addr_in = 2'h0;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic mstr_start_in = 1'b0;
    logic arb_lost_in = 1'b0;
    logic [7:0] rdata_out, ab;
    logic irq_out, sda_oe_n_out, sda_drv_out, scl_w, bm_sda;
    logic [6:0] own, oth;
    logic [15:0] exp_q[$];
    int num_errors = 0;
    int total_checks = 0;
    int w, k;
    wire sda_w = bm_sda & (sda_oe_n_out | sda_drv_out);
    always #5 clk_in = ~clk_in;
    tss_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
        .scl_in(scl_w), .sda_in(sda_w), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .mstr_start_in(mstr_start_in), .arb_lost_in(arb_lost_in),
        .rdata_out(rdata_out), .irq_out(irq_out),
        .sda_oe_n_out(sda_oe_n_out), .sda_drv_out(sda_drv_out));
    tss_bus_master bm (.sda_in(sda_w), .scl_out(scl_w), .sda_out(bm_sda));
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk8(input string n, input logic [7:0] e, m, g);
        total_checks++;
        if ((g & m) !== (e & m)) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e & m, g & m);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic cfg(input logic sie, pie, rel);
        wr(`TSS_ADDR_CTRL, {1'b0, rel, 1'b0, pie, w[0], 1'b0, sie, 1'b0});
    endtask
    task automatic ex(input logic [7:0] v, m);
        exp_q.push_back({m, v});
    endtask
    task automatic xa(input logic [7:0] b, v, m, input int ea);
        logic a;
        if (m != 8'h00)
            ex(v, m);
        bm.send_byte(b, a);
        if (ea < 2)
            chk8("ack", 8'(ea), 8'h01, {7'h00, a});
    endtask
    task automatic xd(input logic e);
        ex(e ? 8'h20 : 8'h10, w ? 8'hf3 : 8'hf7);
        xa(8'($urandom), 8'h00, 8'h00, 2);
    endtask
    task automatic drain();
        int n;
        for (n = 0; n < 200 && exp_q.size() != 0; n++)
            @(posedge clk_in);
        if (exp_q.size() != 0) begin
            chk8("pending", 8'h00, 8'hff, 8'hff);
            stop_test();
        end
    endtask
    task automatic fin(input logic p);
        if (p)
            ex(8'h01, 8'hff);
        bm.stop_cond();
        drain();
    endtask
    // Status read after each irq, matched to the oldest note
    initial forever begin
        @(posedge clk_in);
        if (irq_out === 1'b1) begin
            rd_in <= 1'b1;
            addr_in <= `TSS_ADDR_STAT;
            @(posedge clk_in);
            rd_in <= 1'b0;
            @(negedge clk_in);
            if (exp_q.size() == 0)
                chk8("irq", 8'h00, 8'hff, 8'hff);
            else
                chk8("status", exp_q[0][7:0], exp_q[0][15:8], rdata_out);
            if (exp_q.size() != 0)
                void'(exp_q.pop_front());
        end
    end
    initial begin
        own = 7'h08 + 7'($urandom(32'hf0ea0368) % 96);
        oth = own ^ 7'h01;
        repeat (8) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        wr(`TSS_ADDR_OWN, {own, 1'b0});
        for (w = 0; w < 2; w++) begin
            cfg(0, 1, 0);
            bm.start_cond();
            xa({own, 1'b0}, 8'h16, 8'hf7, 1);
            xd(0);
            xd(0);
            bm.start_cond();
            xa({own, 1'b0}, 8'h16, 8'hf7, 1);
            xd(0);
            bm.start_cond();
            ex(8'h22, 8'hf7);
            if (w)
                ex(8'h26, 8'hf7);
            xa(8'hf0, 8'h00, 8'h00, 2);
            xd(1);
            bm.start_cond();
            xa({oth, 1'b0}, 8'h02, 8'hf3, 0);
            xa(8'($urandom), 8'h00, 8'h00, 2);
            fin(1);
            cfg(w[0], w[0], 0);
            if (w)
                ex(8'h02, 8'hff);
            bm.start_cond();
            xa({oth, 1'b0}, 8'h00, 8'h00, 0);
            xa(8'($urandom), 8'h00, 8'h00, 2);
            fin(w[0]);
            for (k = 0; k < 4 - w; k++) begin
                cfg(1, 1, 0);
                @(posedge clk_in) mstr_start_in <= 1'b1;
                @(posedge clk_in) mstr_start_in <= 1'b0;
                ex(8'h8a, 8'hff);
                bm.start_cond();
                ex(k == 0 ? 8'h56 : k == 1 ? 8'h46 : 8'h62,
                    k == 1 ? 8'hff : 8'hf7);
                if (w && k == 2)
                    ex(8'h26, 8'hf7);
                ab = k == 0 ? {own, 1'b0} : k == 1 ? {oth, 1'b0} : 8'hf0;
                fork
                    xa(ab, 8'h00, 8'h00, k < 2 ? 1 - k : 2);
                    begin
                        repeat (30) @(posedge clk_in);
                        arb_lost_in <= 1'b1;
                        @(posedge clk_in) arb_lost_in <= 1'b0;
                    end
                join
                if (k == 3)
                    cfg(1, 1, 1);
                if (k == 0 || k == 2)
                    xd(k == 2);
                else
                    xa(8'($urandom), 8'h00, 8'h00, 2);
                fin(1);
            end
        end
        stop_test();
    end
endmodule // testbench
`default_nettype wire
